// ==== rtl/sms_cfg.svh ====
// Register map, field positions, reset values and timing counts
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH
`define SMS_A_CTRL1   3'h0
`define SMS_A_CTRL2   3'h1
`define SMS_A_BAUD    3'h2
`define SMS_A_STAT    3'h3
`define SMS_A_DATA    3'h5
`define SMS_C1_RXIE   7
`define SMS_C1_EN     6
`define SMS_C1_TXIE   5
`define SMS_C1_MASTER_SELECT   4
`define SMS_C1_CLOCK_POLARITY_SELECT   3
`define SMS_C1_CLOCK_PHASE_SELECT   2
`define SMS_C1_SOE    1
`define SMS_C1_LSBF   0
`define SMS_C2_FDE    4
`define SMS_ST_RXF    7
`define SMS_ST_TEF    5
`define SMS_ST_MODE_FAULT_FLAG   4
`define SMS_C1_RST    8'h00
`define SMS_C2_RST    8'h00
`define SMS_BAUD_RST  8'h0B
`define SMS_DATA_RST  8'h00
`define SMS_EDGES     5'h10
`endif

// ==== rtl/sms_pkg.sv ====
// Shared types of the serial shifter ends
package sms_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_GAP  = 2'b11
	} sms_state_t;
endpackage

// ==== rtl/sms_if.sv ====
// Serial link between the unit and its partner, with pin resolution
`timescale 1ns/10ps
interface sms_if;
	logic dev_sclk, dev_sclk_oe, dev_mosi, dev_mosi_oe;
	logic dev_miso, dev_miso_oe, dev_ss_n, dev_ss_n_oe;
	logic ptn_sclk, ptn_sclk_oe, ptn_mosi, ptn_mosi_oe;
	logic ptn_miso, ptn_miso_oe, ptn_ss_n, ptn_ss_n_oe;
	logic serial_clock_pin, mosi, miso, ss_n;
	// Undriven select floats high as if pulled up; other pins rest low
	assign serial_clock_pin = dev_sclk_oe ? dev_sclk : (ptn_sclk_oe ? ptn_sclk : 1'b0);
	assign mosi = dev_mosi_oe ? dev_mosi : (ptn_mosi_oe ? ptn_mosi : 1'b0);
	assign miso = dev_miso_oe ? dev_miso : (ptn_miso_oe ? ptn_miso : 1'b0);
	assign ss_n = dev_ss_n_oe ? dev_ss_n : (ptn_ss_n_oe ? ptn_ss_n : 1'b1);
	modport dev (
		output dev_sclk, dev_sclk_oe, dev_mosi, dev_mosi_oe,
		output dev_miso, dev_miso_oe, dev_ss_n, dev_ss_n_oe,
		input  serial_clock_pin, mosi, miso, ss_n
	);
	modport ptn (
		output ptn_sclk, ptn_sclk_oe, ptn_mosi, ptn_mosi_oe,
		output ptn_miso, ptn_miso_oe, ptn_ss_n, ptn_ss_n_oe,
		input  serial_clock_pin, mosi, miso, ss_n
	);
endinterface

// ==== rtl/sms_ptn.sv ====
// Far end of the link: a simple single-byte SPI master or slave
`timescale 1ns/10ps
`include "sms_cfg.svh"
module sms_ptn #(
	parameter logic [7:0] HALF_CYCLES = 8'h0C
) (
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	input  wire logic       master_mode_in,
	input  wire logic       clock_polarity_select_in,
	input  wire logic       clock_phase_select_in,
	input  wire logic       lsb_first_in,
	input  wire logic       start_in,
	input  wire logic [7:0] tx_in,
	output logic            busy_out,
	output logic            done_out,
	output logic      [7:0] rx_out,
	sms_if.ptn              link
);
	sms_pkg::sms_state_t state;
	sms_pkg::sms_state_t next_state;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [7:0] div_cnt;
	logic [4:0] edge_n;
	logic [7:0] shifter;
	logic [7:0] tx_hold;
	logic [7:0] next_shift;
	logic       pend;
	logic       samp;
	logic       dout;
	logic       sclk_q;
	logic       ss_q;
	logic       sclk_d;
	logic       ss_d;
	logic       sel;
	logic       tick;
	logic       edge_ev;
	logic       shift_ev;
	logic       start;
	logic       done;
	logic       abort;

	always_ff @(posedge ref_clk_in) begin
		sync1  <= {link.serial_clock_pin, link.mosi, link.miso, link.ss_n};
		sync2  <= sync1;
		sclk_d <= sync2[3];
		ss_d   <= sync2[0];
	end

	assign sel      = !master_mode_in && !sync2[0];
	assign tick     = (div_cnt == HALF_CYCLES - 8'h01);
	assign edge_ev  = (state == sms_pkg::ST_RUN) && (edge_n < `SMS_EDGES)
		&& (master_mode_in ? tick : (sel && sync2[3] != sclk_d));
	assign shift_ev = edge_ev && (edge_n[0] != clock_phase_select_in);
	// Slave with phase 0 waits for a fresh select fall per byte
	assign start    = (state == sms_pkg::ST_IDLE)
		&& (master_mode_in ? pend : (sel && (clock_phase_select_in || ss_d)));
	assign done     = (state == sms_pkg::ST_RUN) && (edge_n == `SMS_EDGES)
		&& (!master_mode_in || tick);
	assign abort    = (state == sms_pkg::ST_RUN) && !master_mode_in && !sel;
	assign next_shift = lsb_first_in ? {samp, shifter[7:1]} : {shifter[6:0], samp};

	always_comb begin
		next_state = state;
		case (state)
			sms_pkg::ST_IDLE: if (start) next_state = sms_pkg::ST_RUN;
			sms_pkg::ST_RUN: begin
				if (abort) begin
					next_state = sms_pkg::ST_IDLE;
				end else if (done) begin
					next_state = master_mode_in ? sms_pkg::ST_GAP : sms_pkg::ST_IDLE;
				end
			end
			sms_pkg::ST_GAP: if (tick) next_state = sms_pkg::ST_IDLE;
			default: next_state = sms_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state  <= sms_pkg::ST_IDLE;
			edge_n <= 5'h00;
		end else begin
			state <= next_state;
			if (start || abort) edge_n <= 5'h00;
			else if (edge_ev) edge_n <= edge_n + 5'h01;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in || tick || state == sms_pkg::ST_IDLE) div_cnt <= 8'h00;
		else div_cnt <= div_cnt + 8'h01;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pend    <= 1'b0;
			tx_hold <= 8'h00;
		end else if (start_in) begin
			pend    <= 1'b1;
			tx_hold <= tx_in;
		end else if (start) begin
			pend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			shifter <= 8'h00;
			samp    <= 1'b0;
			dout    <= 1'b0;
		end else begin
			if (edge_ev && !shift_ev) samp <= master_mode_in ? sync2[1] : sync2[2];
			if (start) begin
				shifter <= tx_hold;
				dout    <= lsb_first_in ? tx_hold[0] : tx_hold[7];
			end else if (shift_ev && edge_n == 5'h00) begin
				dout <= lsb_first_in ? shifter[0] : shifter[7];
			end else if (shift_ev) begin
				shifter <= next_shift;
				dout    <= lsb_first_in ? next_shift[0] : next_shift[7];
			end else if (done && clock_phase_select_in) begin
				shifter <= next_shift;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sclk_q   <= 1'b0;
			ss_q     <= 1'b1;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			rx_out   <= 8'h00;
		end else begin
			if (state != sms_pkg::ST_RUN) sclk_q <= clock_polarity_select_in;
			else if (edge_ev) sclk_q <= ~sclk_q;
			ss_q     <= !(master_mode_in && next_state == sms_pkg::ST_RUN);
			busy_out <= pend || (next_state != sms_pkg::ST_IDLE);
			done_out <= done;
			if (done) rx_out <= clock_phase_select_in ? next_shift : shifter;
		end
	end

	assign link.ptn_sclk    = sclk_q;
	assign link.ptn_sclk_oe = master_mode_in;
	assign link.ptn_mosi    = dout;
	assign link.ptn_mosi_oe = master_mode_in;
	assign link.ptn_miso    = dout;
	assign link.ptn_miso_oe = sel;
	assign link.ptn_ss_n    = ss_q;
	assign link.ptn_ss_n_oe = master_mode_in;
endmodule

// ==== rtl/sms_dev.sv ====
// SPI unit: double-buffered byte shifter, master and slave roles, register port
// Functional notes
// - Data reads rx buffer, writes tx buffer
// - Master data write starts a transfer
// - Software writes only while tx-empty set
// - Unread rx buffer keeps old byte silently
// - Free shifter takes queued byte, sets tx-empty
// - Eight clocks, shift out and in together
// - Transfer end fills rx buffer, sets rx-full
// - Queued byte starts next transfer automatically
// - MSB first unless lsb-first enable set
// - External master holds select low throughout
// - Phase 0 needs select high between bytes
// - Sample one edge, change half cycle later
// - Polarity inverts clock, phase picks relation
// - Phase 1 master select leads half cycle
// - Phase 1 first edge drives first bit
// - Phase 0 master select trails half cycle
// - Phase 0 first bit at select fall
// - Rx-full or fault interrupt when enabled
// - Tx-empty interrupt when enabled, else polled
// - Handler checks flags, clears them early
// - Rx-full clears by status then data read
// - Data write needs prior status read
// - Fault sets flag, drops master, drivers off
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "sms_cfg.svh"
module sms_dev (
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	output logic            irq_out,
	sms_if.dev              link
);
	sms_pkg::sms_state_t state;
	sms_pkg::sms_state_t next_state;
	logic [7:0] ctrl1;
	logic [7:0] ctrl2;
	logic [7:0] baud;
	logic [7:0] tx_buf;
	logic [7:0] serial_data_register;
	logic [7:0] shifter;
	logic [7:0] next_shift;
	logic [7:0] div_cnt;
	logic [4:0] edge_n;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       tx_full;
	logic       tx_buffer_empty_flag;
	logic       rx_buffer_full_flag;
	logic       mode_fault_flag;
	logic       tef_armed;
	logic       rxf_armed;
	logic       mode_fault_flag_armed;
	logic       samp;
	logic       dout;
	logic       sclk_q;
	logic       ss_q;
	logic       sclk_d;
	logic       ss_d;
	logic       sclk_oe;
	logic       miso_oe;
	logic       ss_oe;
	logic       en;
	logic       master_select;
	logic       clock_polarity_select;
	logic       clock_phase_select;
	logic       lsb_first_enable;
	logic       fault_detect_enable;
	logic       select_output_enable;
	logic       s_sclk;
	logic       s_mosi;
	logic       s_miso;
	logic       s_ss_n;
	logic       tick;
	logic       sel;
	logic       edge_ev;
	logic       shift_ev;
	logic       start;
	logic       done;
	logic       abort;
	logic       fault;
	logic       acc_wr;
	logic       rd_stat;
	logic       rd_dat;
	logic       wr_c1;
	logic       rx_clr;

	assign en                    = ctrl1[`SMS_C1_EN];
	assign master_select         = ctrl1[`SMS_C1_MASTER_SELECT];
	assign clock_polarity_select = ctrl1[`SMS_C1_CLOCK_POLARITY_SELECT];
	assign clock_phase_select    = ctrl1[`SMS_C1_CLOCK_PHASE_SELECT];
	assign select_output_enable  = ctrl1[`SMS_C1_SOE];
	assign lsb_first_enable      = ctrl1[`SMS_C1_LSBF];
	assign fault_detect_enable   = ctrl2[`SMS_C2_FDE];

	// Pins come from outside this clock domain
	always_ff @(posedge ref_clk_in) begin
		sync1 <= {link.serial_clock_pin, link.mosi, link.miso, link.ss_n};
		sync2 <= sync1;
	end
	assign {s_sclk, s_mosi, s_miso, s_ss_n} = sync2;

	always_ff @(posedge ref_clk_in) begin
		sclk_d <= s_sclk;
		ss_d   <= s_ss_n;
	end

	assign rd_stat = rd_in && (addr_in == `SMS_A_STAT);
	assign rd_dat  = rd_in && (addr_in == `SMS_A_DATA);
	assign wr_c1   = wr_in && (addr_in == `SMS_A_CTRL1);
	assign acc_wr  = wr_in && (addr_in == `SMS_A_DATA) && tef_armed && tx_buffer_empty_flag;
	assign rx_clr  = rd_dat && rxf_armed;

	assign tick     = (div_cnt == baud);
	assign sel      = en && !master_select && !s_ss_n;
	assign fault    = en && master_select && fault_detect_enable
		&& !select_output_enable && !s_ss_n;
	assign edge_ev  = (state == sms_pkg::ST_RUN) && (edge_n < `SMS_EDGES)
		&& (master_select ? tick : (sel && s_sclk != sclk_d));
	// Edges alternate sample and shift; phase picks which comes first
	assign shift_ev = edge_ev && (edge_n[0] != clock_phase_select);
	// A phase 0 slave only starts on a fresh select fall
	assign start    = (state == sms_pkg::ST_IDLE) && en && (master_select ? tx_full
		: (sel && (clock_phase_select || ss_d)));
	assign done     = (state == sms_pkg::ST_RUN) && (edge_n == `SMS_EDGES)
		&& (!master_select || tick);
	assign abort    = (state == sms_pkg::ST_RUN)
		&& (master_select ? (!en || fault) : !sel);
	assign next_shift = lsb_first_enable ? {samp, shifter[7:1]}
		: {shifter[6:0], samp};

	always_comb begin
		next_state = state;
		case (state)
			sms_pkg::ST_IDLE: if (start) next_state = sms_pkg::ST_RUN;
			sms_pkg::ST_RUN: begin
				if (abort) begin
					next_state = sms_pkg::ST_IDLE;
				end else if (done) begin
					next_state = master_select ? sms_pkg::ST_GAP : sms_pkg::ST_IDLE;
				end
			end
			// Keeps select high for a half clock between bytes
			sms_pkg::ST_GAP: if (tick || !master_select) next_state = sms_pkg::ST_IDLE;
			default: next_state = sms_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state  <= sms_pkg::ST_IDLE;
			edge_n <= 5'h00;
		end else begin
			state <= next_state;
			if (start || abort) edge_n <= 5'h00;
			else if (edge_ev) edge_n <= edge_n + 5'h01;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in || tick || state == sms_pkg::ST_IDLE) div_cnt <= 8'h00;
		else div_cnt <= div_cnt + 8'h01;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			shifter <= 8'h00;
			samp    <= 1'b0;
			dout    <= 1'b0;
		end else begin
			if (edge_ev && !shift_ev) samp <= master_select ? s_miso : s_mosi;
			if (start && tx_full) begin
				shifter <= tx_buf;
				dout    <= lsb_first_enable ? tx_buf[0] : tx_buf[7];
			end else if (start) begin
				dout <= lsb_first_enable ? shifter[0] : shifter[7];
			end else if (shift_ev && edge_n == 5'h00) begin
				dout <= lsb_first_enable ? shifter[0] : shifter[7];
			end else if (shift_ev) begin
				shifter <= next_shift;
				dout    <= lsb_first_enable ? next_shift[0] : next_shift[7];
			end else if (done && clock_phase_select) begin
				shifter <= next_shift;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sclk_q <= 1'b0;
			ss_q   <= 1'b1;
		end else begin
			if (state != sms_pkg::ST_RUN || !master_select) sclk_q <= clock_polarity_select;
			else if (edge_ev) sclk_q <= ~sclk_q;
			// Low one half clock before the first edge, high one after the last
			ss_q <= !(master_select && next_state == sms_pkg::ST_RUN);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sclk_oe <= 1'b0;
			miso_oe <= 1'b0;
			ss_oe   <= 1'b0;
		end else begin
			sclk_oe <= en && master_select && !fault;
			miso_oe <= sel && !mode_fault_flag;
			ss_oe   <= en && master_select && fault_detect_enable && select_output_enable;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ctrl1 <= `SMS_C1_RST;
			ctrl2 <= `SMS_C2_RST;
			baud  <= `SMS_BAUD_RST;
		end else begin
			if (wr_c1) ctrl1 <= wdata_in;
			if (fault) ctrl1[`SMS_C1_MASTER_SELECT] <= 1'b0;
			if (wr_in && addr_in == `SMS_A_CTRL2) ctrl2 <= wdata_in;
			if (wr_in && addr_in == `SMS_A_BAUD) baud <= wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			tx_buf               <= `SMS_DATA_RST;
			tx_full              <= 1'b0;
			tx_buffer_empty_flag <= 1'b1;
			tef_armed            <= 1'b0;
		end else begin
			if (acc_wr) tx_buf <= wdata_in;
			if (start && tx_full) begin
				tx_full              <= 1'b0;
				tx_buffer_empty_flag <= 1'b1;
			end else if (acc_wr) begin
				tx_full              <= 1'b1;
				tx_buffer_empty_flag <= 1'b0;
			end
			if (rd_stat && tx_buffer_empty_flag) tef_armed <= 1'b1;
			else if (wr_in && addr_in == `SMS_A_DATA) tef_armed <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			serial_data_register <= `SMS_DATA_RST;
			rx_buffer_full_flag  <= 1'b0;
			rxf_armed            <= 1'b0;
		end else begin
			// An unread byte blocks the new one; nothing flags the loss
			if (done && (!rx_buffer_full_flag || rx_clr)) begin
				serial_data_register <= clock_phase_select ? next_shift : shifter;
				rx_buffer_full_flag  <= 1'b1;
			end else if (rx_clr) begin
				rx_buffer_full_flag <= 1'b0;
			end
			if (rd_stat && rx_buffer_full_flag) rxf_armed <= 1'b1;
			else if (rd_dat) rxf_armed <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			mode_fault_flag <= 1'b0;
			mode_fault_flag_armed      <= 1'b0;
		end else begin
			if (fault) mode_fault_flag <= 1'b1;
			else if (wr_c1 && mode_fault_flag_armed) mode_fault_flag <= 1'b0;
			if (rd_stat && mode_fault_flag) mode_fault_flag_armed <= 1'b1;
			else if (wr_c1) mode_fault_flag_armed <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rdata_out <= 8'h00;
			irq_out   <= 1'b0;
		end else begin
			rdata_out <= 8'h00;
			if (rd_in) begin
				case (addr_in)
					`SMS_A_CTRL1: rdata_out <= ctrl1;
					`SMS_A_CTRL2: rdata_out <= ctrl2;
					`SMS_A_BAUD:  rdata_out <= baud;
					`SMS_A_STAT: begin
						rdata_out[`SMS_ST_RXF]  <= rx_buffer_full_flag;
						rdata_out[`SMS_ST_TEF]  <= tx_buffer_empty_flag;
						rdata_out[`SMS_ST_MODE_FAULT_FLAG] <= mode_fault_flag;
					end
					`SMS_A_DATA:  rdata_out <= serial_data_register;
					default:      rdata_out <= 8'h00;
				endcase
			end
			irq_out <= (ctrl1[`SMS_C1_RXIE] && (rx_buffer_full_flag || mode_fault_flag))
				|| (ctrl1[`SMS_C1_TXIE] && tx_buffer_empty_flag);
		end
	end

	assign link.dev_sclk    = sclk_q;
	assign link.dev_sclk_oe = sclk_oe;
	assign link.dev_mosi    = dout;
	assign link.dev_mosi_oe = sclk_oe;
	assign link.dev_miso    = dout;
	assign link.dev_miso_oe = miso_oe;
	assign link.dev_ss_n    = ss_q;
	assign link.dev_ss_n_oe = ss_oe;
endmodule

// ==== verif/sms_checker.sv ====
// Link-side checks of the unit against its partner
`timescale 1ns/10ps
module sms_checker #(
	parameter int HALF = 6
) (
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	input  wire logic       dev_sclk,
	input  wire logic       dev_sclk_oe,
	input  wire logic       dev_mosi,
	input  wire logic       dev_mosi_oe,
	input  wire logic       dev_miso_oe,
	input  wire logic       dev_ss_n,
	input  wire logic       dev_ss_n_oe,
	input  wire logic       serial_clock_pin,
	input  wire logic       ss_n
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	logic [4:0] edges;
	logic [7:0] since;
	logic       chg_d;

	// Edges are counted on the resolved pins so either end may be master
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || ss_n) begin
			edges <= 5'h00;
		end else if ($changed(serial_clock_pin)) begin
			edges <= edges + 5'h01;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in || $changed(dev_sclk)) begin
			since <= 8'h00;
		end else if (since != 8'hFF) begin
			since <= since + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		chg_d <= $changed(dev_sclk) || $fell(dev_ss_n);
	end

	ss_lead_a: assert property ($fell(dev_ss_n) && dev_ss_n_oe
		|-> $stable(dev_sclk)[*5] ##[1:2] $changed(dev_sclk))
		else $error("First clock edge not half a period after select fall");
	ss_trail_a: assert property ($rose(dev_ss_n) && dev_ss_n_oe
		|-> since inside {[HALF - 2:HALF - 1]})
		else $error("Select rise not half a period after last edge");
	edge_count_a: assert property ($rose(ss_n) |-> edges == 5'h10)
		else $error("Frame did not carry sixteen clock edges");
	select_gap_a: assert property ($rose(dev_ss_n) && dev_ss_n_oe |-> dev_ss_n[*5])
		else $error("Select gap between bytes too short");
	sclk_idle_a: assert property (dev_sclk_oe && $past(dev_sclk_oe, 2) && dev_ss_n_oe
		&& dev_ss_n && $past(dev_ss_n) |-> $stable(dev_sclk))
		else $error("Master clock moved between frames");
	mosi_shift_a: assert property (dev_ss_n_oe && !dev_ss_n && dev_mosi_oe
		&& $changed(dev_mosi) |-> $changed(dev_sclk) || $fell(dev_ss_n) || chg_d)
		else $error("Master data changed away from a shift edge");
	miso_drive_a: assert property ($fell(ss_n) && !dev_sclk_oe
		|-> ##[1:4] dev_miso_oe)
		else $error("Selected slave did not drive its data line");
	miso_release_a: assert property (ss_n[*6] |-> !dev_miso_oe)
		else $error("Unselected slave still drives its data line");

	cover property ($rose(dev_ss_n) && dev_ss_n_oe);
	cover property ($fell(ss_n) && !dev_sclk_oe);
	cover property ($rose(ss_n) && edges == 5'h10);
endmodule

// ==== verif/tb_spi_master_slave_shifter.sv ====
// Bench joining the unit and its partner over the link
`timescale 1ns/10ps
`include "sms_cfg.svh"
module tb_spi_master_slave_shifter;
	localparam int HALF = 6;
	logic       ref_clk_in;
	logic       reset_in;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       irq;
	logic       p_master;
	logic       p_clock_polarity_select;
	logic       p_clock_phase_select;
	logic       p_lsbf;
	logic       p_start;
	logic [7:0] p_tx;
	logic       p_busy;
	logic       p_done;
	logic [7:0] p_rx;
	logic       cur_clock_phase_select;
	logic       sclk_q;
	logic [4:0] ecnt;
	logic [7:0] mo_b;
	logic [7:0] mi_b;
	logic [7:0] mo_q[$];
	logic [7:0] mi_q[$];
	int         mismatches;
	int         n_tests;

	sms_if sms_if_inst ();
	sms_dev sms_dev_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
		.link(sms_if_inst.dev));
	sms_ptn #(.HALF_CYCLES(8'h08)) sms_ptn_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.master_mode_in(p_master), .clock_polarity_select_in(p_clock_polarity_select), .clock_phase_select_in(p_clock_phase_select), .lsb_first_in(p_lsbf),
		.start_in(p_start), .tx_in(p_tx), .busy_out(p_busy), .done_out(p_done), .rx_out(p_rx),
		.link(sms_if_inst.ptn));
	sms_checker #(.HALF(HALF)) sms_checker_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.dev_sclk(sms_if_inst.dev_sclk), .dev_sclk_oe(sms_if_inst.dev_sclk_oe),
		.dev_mosi(sms_if_inst.dev_mosi), .dev_mosi_oe(sms_if_inst.dev_mosi_oe),
		.dev_miso_oe(sms_if_inst.dev_miso_oe), .dev_ss_n(sms_if_inst.dev_ss_n),
		.dev_ss_n_oe(sms_if_inst.dev_ss_n_oe), .serial_clock_pin(sms_if_inst.serial_clock_pin),
		.ss_n(sms_if_inst.ss_n));

	// Wire monitor: captures both data lines at sample edges, first bit lands in bit 7
	always @(posedge ref_clk_in) begin
		sclk_q <= sms_if_inst.serial_clock_pin;
		if (sms_if_inst.ss_n) begin
			ecnt <= 5'h00;
		end else if (sms_if_inst.serial_clock_pin !== sclk_q) begin
			ecnt <= ecnt + 5'h01;
			if (ecnt[0] == cur_clock_phase_select) begin
				mo_b <= {mo_b[6:0], sms_if_inst.mosi};
				mi_b <= {mi_b[6:0], sms_if_inst.miso};
				if (ecnt == 5'h0E + 5'(cur_clock_phase_select)) begin
					mo_q.push_back({mo_b[6:0], sms_if_inst.mosi});
					mi_q.push_back({mi_b[6:0], sms_if_inst.miso});
				end
			end
		end
	end

	function automatic logic [7:0] rev8(input logic [7:0] v);
		return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic send(input logic [7:0] d);
		logic [7:0] s;
		rd_reg(`SMS_A_STAT, s);
		wr_reg(`SMS_A_DATA, d);
	endtask

	task automatic take_rx(output logic [7:0] d);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 300 && s[`SMS_ST_RXF] !== 1'b1; i++) begin
			rd_reg(`SMS_A_STAT, s);
		end
		chk(s & 8'h80, 8'h80);
		rd_reg(`SMS_A_DATA, d);
	endtask

	task automatic ptn_arm(input logic [7:0] b);
		@(posedge ref_clk_in);
		p_tx <= b;
		p_start <= 1'b1;
		@(posedge ref_clk_in);
		p_start <= 1'b0;
	endtask

	// Master is dropped while the format changes so the clock never glitches mid-config
	task automatic setup(input logic m, input logic pol, input logic pha, input logic lsb);
		wr_reg(`SMS_A_CTRL1, 8'h40);
		p_master <= !m;
		p_clock_polarity_select <= pol;
		p_clock_phase_select <= pha;
		p_lsbf <= lsb;
		cur_clock_phase_select = pha;
		wr_reg(`SMS_A_CTRL1, {3'b010, m, pol, pha, m, lsb});
		repeat (4) @(posedge ref_clk_in);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task automatic s_reset();
		logic [7:0] d;
		rd_reg(`SMS_A_DATA, d);
		chk(d, `SMS_DATA_RST);
		rd_reg(`SMS_A_STAT, d);
		chk(d, 8'h20);
		wr_reg(3'h7, 8'hA5);
		rd_reg(3'h7, d);
		chk(d, 8'h00);
	endtask

	task automatic s_formats();
		logic [7:0] d;
		logic [7:0] tx;
		for (int f = 0; f < 8; f++) begin
			tx = 8'h1D ^ 8'(f * 37);
			setup(1'b1, f[2], f[1], f[0]);
			chk({7'h00, sms_if_inst.serial_clock_pin}, {7'h00, f[2]});
			ptn_arm(~tx);
			send(tx);
			take_rx(d);
			chk(d, ~tx);
			chk(mo_q.pop_front(), f[0] ? rev8(tx) : tx);
			chk(mi_q.pop_front(), f[0] ? rev8(~tx) : ~tx);
			rd_reg(`SMS_A_STAT, d);
			chk(d & 8'h80, 8'h00);
		end
	endtask

	task automatic s_queue();
		logic [7:0] d;
		setup(1'b1, 1'b0, 1'b1, 1'b0);
		ptn_arm(8'h5A);
		send(8'hC3);
		rd_reg(`SMS_A_STAT, d);
		chk(d & 8'h20, 8'h20);
		wr_reg(`SMS_A_DATA, 8'h96);
		rd_reg(`SMS_A_STAT, d);
		chk(d & 8'h20, 8'h00);
		wr_reg(`SMS_A_DATA, 8'h0F);
		// Partner sends a different second byte so a lost overrun byte is visible
		ptn_arm(8'hA5);
		for (int i = 0; i < 2000 && mo_q.size() < 2; i++) begin
			wait_cyc(1);
		end
		wait_cyc(20);
		take_rx(d);
		chk(d, 8'h5A);
		wait_cyc(150);
		chk(mo_q.pop_front(), 8'hC3);
		chk(mo_q.pop_front(), 8'h96);
		chk(8'(mo_q.size()), 8'h00);
		mi_q.delete();
	endtask

	task automatic s_slave();
		logic [7:0] d;
		for (int f = 0; f < 2; f++) begin
			setup(1'b0, 1'b0, f[0], 1'b0);
			send(8'h3C + 8'(f));
			ptn_arm(8'hA1 ^ 8'(f));
			for (int i = 0; i < 2000 && p_done !== 1'b1; i++) begin
				wait_cyc(1);
			end
			chk({7'h00, p_busy}, 8'h01);
			chk(p_rx, 8'h3C + 8'(f));
			take_rx(d);
			chk(d, 8'hA1 ^ 8'(f));
		end
		mo_q.delete();
		mi_q.delete();
	endtask

	task automatic s_irq();
		logic [7:0] d;
		setup(1'b1, 1'b0, 1'b0, 1'b0);
		ptn_arm(8'h77);
		send(8'h11);
		for (int i = 0; i < 2000 && mo_q.size() < 1; i++) begin
			wait_cyc(1);
		end
		wait_cyc(HALF + 4);
		wait_cyc(2);
		chk({7'h00, irq}, 8'h00);
		wr_reg(`SMS_A_CTRL1, 8'hD2);
		wait_cyc(2);
		chk({7'h00, irq}, 8'h01);
		take_rx(d);
		wait_cyc(2);
		chk({7'h00, irq}, 8'h00);
		wr_reg(`SMS_A_CTRL1, 8'h72);
		wait_cyc(2);
		chk({7'h00, irq}, 8'h01);
		wr_reg(`SMS_A_CTRL1, 8'h52);
		mo_q.delete();
		mi_q.delete();
	endtask

	// Partner master selects the unit while it is master with select as fault input
	task automatic s_fault();
		logic [7:0] d;
		wr_reg(`SMS_A_CTRL1, 8'h50);
		p_master <= 1'b1;
		ptn_arm(8'h3C);
		for (int i = 0; i < 2000 && p_done !== 1'b1; i++) begin
			wait_cyc(1);
		end
		chk(p_rx, 8'h00);
		rd_reg(`SMS_A_STAT, d);
		chk(d & 8'h10, 8'h10);
		rd_reg(`SMS_A_CTRL1, d);
		chk(d & 8'h10, 8'h00);
		wr_reg(`SMS_A_CTRL1, 8'h40);
		p_master <= 1'b0;
		rd_reg(`SMS_A_STAT, d);
		chk(d & 8'h10, 8'h00);
		mo_q.delete();
		mi_q.delete();
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		reset_in = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		p_master = 1'b0;
		p_clock_polarity_select = 1'b0;
		p_clock_phase_select = 1'b0;
		p_lsbf = 1'b0;
		p_start = 1'b0;
		p_tx = 8'h00;
		cur_clock_phase_select = 1'b0;
		mismatches = 0;
		n_tests = 0;
		repeat (20) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		s_reset();
		wr_reg(`SMS_A_CTRL2, 8'h10);
		wr_reg(`SMS_A_BAUD, 8'(HALF - 1));
		s_formats();
		s_queue();
		s_slave();
		s_irq();
		s_fault();
		complete_run();
	end

	// About ten times the expected length of the whole sequence
	initial begin
		#100000;
		mismatches++;
		$display("ERROR t=%0t: watchdog expired", $time);
		complete_run();
	end
endmodule
